// [hdl/sps_cfg.svh]
`ifndef SPS_CFG_SVH
`define SPS_CFG_SVH

// ----
// register byte offsets
// ----
`define SPS_OFS_CTRL   6'h00
`define SPS_OFS_TIMEA  6'h04
`define SPS_OFS_TIMEB  6'h08
`define SPS_OFS_LIMIT  6'h0C
`define SPS_OFS_CREEP  6'h10
`define SPS_OFS_RANGE  6'h14
`define SPS_OFS_TARGET 6'h18
`define SPS_OFS_STATUS 6'h1C
`define SPS_OFS_POS    6'h20

// ----
// field positions
// ----
`define SPS_F_PSEL     0
`define SPS_F_PMODE    8
`define SPS_F_BCE      16
`define SPS_F_ANS_EN   24
`define SPS_F_LO       0
`define SPS_F_HI       16
`define SPS_F_ST_BRK   4
`define SPS_F_ST_ERR   5
`define SPS_F_ST_POK   6
`define SPS_F_ST_ANS   7

// ----
// setting codes
// ----
`define SPS_PSEL_SIMPLE 8'h02
`define SPS_PMODE_LIMIT 1'b0
`define SPS_BCE_DC      2'h1
`define SPS_BCE_NODC    2'h2

// ----
// reset values
// ----
`define SPS_RST_CTRL   32'h0000_0000
`define SPS_RST_TIMEA  32'h0000_0000
`define SPS_RST_TIMEB  32'h0000_0000
`define SPS_RST_LIMIT  32'h0000_0000
`define SPS_RST_CREEP  32'h0000_0000
`define SPS_RST_RANGE  32'h0000_0000
`define SPS_RST_TARGET 32'h0000_0000

// ----
// limits and timing
// ----
`define SPS_CREEP_MAX  10'h3E8
`define SPS_RANGE_MULT 4
`define SPS_PCT_SCALE  1000
`define SPS_CLK_MHZ    250
`define SPS_TICK_US    10000
`define SPS_TICK_CYCLES (`SPS_TICK_US * `SPS_CLK_MHZ)

`endif

// [hdl/sps_pkg.sv]
package sps_pkg;

  // gray coded along the positioning path
  typedef enum logic [3:0] {
    SPS_IDLE      = 4'h0,
    SPS_CREEP_UP  = 4'h1,
    SPS_REL_WAIT  = 4'h3,
    SPS_ANS_ON    = 4'h2,
    SPS_ACC_WAIT  = 4'h6,
    SPS_RUN       = 4'h7,
    SPS_DECEL     = 4'h5,
    SPS_ANS_OFF   = 4'h4,
    SPS_STOP_WAIT = 4'hC,
    SPS_HOLD      = 4'hD,
    SPS_TRIP      = 4'hF,
    SPS_SPEED     = 4'hE
  } sps_state_e;

  typedef logic [8:0] sps_time_t;

endpackage

// [hdl/sps_timer.sv]
`timescale 1ns/100ps
`include "sps_cfg.svh"

module sps_timer #(
  parameter int TICK_CYCLES = `SPS_TICK_CYCLES
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // control
  input  wire logic             start,
  input  wire sps_pkg::sps_time_t load,
  output      logic             done
);

  logic [31:0]        pre;
  sps_pkg::sps_time_t cnt;
  logic               busy;

  // ----------------------------------------
  // 10 ms prescaler and countdown
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre  <= 32'h0000_0000;
      cnt  <= 9'h000;
      busy <= 1'b0;
    end else if (start) begin
      pre  <= 32'h0000_0000;
      cnt  <= load;
      busy <= (load != 9'h000);
    end else if (busy) begin
      if (pre == 32'(TICK_CYCLES - 1)) begin
        pre <= 32'h0000_0000;
        cnt <= cnt - 9'h001;
        if (cnt == 9'h001) begin
          busy <= 1'b0;
        end
      end else begin
        pre <= pre + 32'h0000_0001;
      end
    end
  end

  assign done = ~busy;

endmodule

// [hdl/sps_seq.sv]
// What this block does
// - speed control while switch input is on
// - position counter held zero during speed mode
// - switch release starts position counting there
// - zero target at switch starts stop
// - switching only with limited position mode
// - brake linked when enable is 01/02
// - answer-back checked against release output
// - release dropped on reaching creep speed
// - stop short by creep displacement at most
// - release wait timer after creep reached
// - acceleration delay after answer or release
// - stopping delay after release output drops
// - confirmation timeout bounds answer-back wait
// - release only when current reaches limit
// - simple position active when selection 02
// - creep displacement 0.0-409.5 percent per rev
// - creep speed capped at 10.00
// - complete output within range times four
// - brake error output and trip on error
// - low current at release trips, brake off
// - answer-back timeout trips with error output
// - after stop DC brake (01) or cut (02)
`timescale 1ns/100ps
`include "sps_cfg.svh"

module sps_seq #(
  parameter int TICK_CYCLES = `SPS_TICK_CYCLES,
  parameter int PULSES_REV  = 4096
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // avalon-mm slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output      logic [31:0] avs_readdata,
  output      logic        avs_waitrequest,
  // run command and drive feedback
  input  wire logic        run_cmd,
  input  wire logic        run_dir,
  input  wire logic [15:0] set_freq,
  input  wire logic [15:0] output_freq,
  input  wire logic [7:0]  output_current,
  input  wire logic [31:0] decel_distance,
  input  wire logic        pos_step,
  input  wire logic        pos_dir,
  // terminals
  input  wire logic        speed_position_switch,
  input  wire logic        brake_answer_in,
  output      logic        brake_release_out,
  output      logic        brake_error_out,
  output      logic        brake_error_trip,
  output      logic        positioning_complete_out,
  // drive commands
  output      logic [15:0] freq_cmd,
  output      logic        dir_reverse,
  output      logic        dc_brake_out,
  output      logic        drive_enable,
  output      logic        speed_mode_out
);

  // ----
  // helpers
  // ----
  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] abs32(input logic [31:0] v);
    return v[31] ? (32'h0000_0000 - v) : v;
  endfunction

  // ----
  // registers
  // ----
  logic [31:0] reg_ctrl;
  logic [31:0] reg_timea;
  logic [31:0] reg_timeb;
  logic [31:0] reg_limit;
  logic [31:0] reg_creep;
  logic [31:0] reg_range;
  logic [31:0] reg_target;
  logic        bus_ack;
  logic        clr_req;
  logic        wr_en;
  logic        wr_status;

  sps_pkg::sps_state_e state;
  sps_pkg::sps_state_e next_state;
  logic [31:0]         cur_pos;
  logic                via_spd;
  logic                tmr_done;
  logic                tmr_start;
  sps_pkg::sps_time_t  tmr_load;

  assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack;
  assign wr_en           = avs_write & ~bus_ack;
  assign wr_status       = wr_en & (avs_address == `SPS_OFS_STATUS) &
                           avs_byteenable[0] & avs_writedata[`SPS_F_ST_ERR];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= (avs_read | avs_write) & ~bus_ack;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_ctrl   <= `SPS_RST_CTRL;
      reg_timea  <= `SPS_RST_TIMEA;
      reg_timeb  <= `SPS_RST_TIMEB;
      reg_limit  <= `SPS_RST_LIMIT;
      reg_creep  <= `SPS_RST_CREEP;
      reg_range  <= `SPS_RST_RANGE;
      reg_target <= `SPS_RST_TARGET;
    end else if (wr_en) begin
      case (avs_address)
        `SPS_OFS_CTRL:   reg_ctrl   <= merge_be(reg_ctrl, avs_writedata, avs_byteenable);
        `SPS_OFS_TIMEA:  reg_timea  <= merge_be(reg_timea, avs_writedata, avs_byteenable);
        `SPS_OFS_TIMEB:  reg_timeb  <= merge_be(reg_timeb, avs_writedata, avs_byteenable);
        `SPS_OFS_LIMIT:  reg_limit  <= merge_be(reg_limit, avs_writedata, avs_byteenable);
        `SPS_OFS_CREEP:  reg_creep  <= merge_be(reg_creep, avs_writedata, avs_byteenable);
        `SPS_OFS_RANGE:  reg_range  <= merge_be(reg_range, avs_writedata, avs_byteenable);
        `SPS_OFS_TARGET: reg_target <= merge_be(reg_target, avs_writedata, avs_byteenable);
        default: begin
        end
      endcase
    end
  end

  // ----
  // setting fields
  // ----
  logic [7:0]         positioning_select;
  logic               position_mode_select;
  logic [1:0]         brake_control_enable;
  logic               answer_assigned;
  sps_pkg::sps_time_t release_wait_time;
  sps_pkg::sps_time_t accel_wait_time;
  sps_pkg::sps_time_t stop_wait_time;
  sps_pkg::sps_time_t confirm_timeout;
  logic [4:0]         release_current_limit;
  logic [9:0]         creep_speed_setting;
  logic [11:0]        creep_displacement;
  logic [13:0]        completion_range;
  logic [15:0]        creep_freq;

  assign positioning_select    = reg_ctrl[`SPS_F_PSEL +: 8];
  assign position_mode_select  = reg_ctrl[`SPS_F_PMODE];
  assign brake_control_enable  = reg_ctrl[`SPS_F_BCE +: 2];
  assign answer_assigned       = reg_ctrl[`SPS_F_ANS_EN];
  assign release_wait_time     = reg_timea[`SPS_F_LO +: 9];
  assign accel_wait_time       = reg_timea[`SPS_F_HI +: 9];
  assign stop_wait_time        = reg_timeb[`SPS_F_LO +: 9];
  assign confirm_timeout       = reg_timeb[`SPS_F_HI +: 9];
  assign release_current_limit = reg_limit[`SPS_F_LO +: 5];
  assign creep_speed_setting   = reg_limit[`SPS_F_HI +: 10];
  assign creep_displacement    = reg_creep[11:0];
  assign completion_range      = reg_range[13:0];
  // creep speed never above 10.00
  assign creep_freq = {6'h00, (creep_speed_setting > `SPS_CREEP_MAX) ?
                              `SPS_CREEP_MAX : creep_speed_setting};

  // ----
  // mode decode
  // ----
  logic pos_on;
  logic switch_ok;
  logic brake_link;
  logic dc_at_stop;

  assign pos_on     = (positioning_select == `SPS_PSEL_SIMPLE);
  assign switch_ok  = pos_on & (position_mode_select == `SPS_PMODE_LIMIT);
  assign brake_link = pos_on & ((brake_control_enable == `SPS_BCE_DC) |
                                (brake_control_enable == `SPS_BCE_NODC));
  assign dc_at_stop = brake_link & (brake_control_enable == `SPS_BCE_DC);

  // ----
  // position tracking
  // ----
  logic [31:0] pos_err;
  logic [31:0] err_abs;
  logic [47:0] lhs_near;
  logic [47:0] rhs_near;
  logic        near_target;
  logic        in_range;
  logic        current_ok;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cur_pos <= 32'h0000_0000;
    end else if (state == sps_pkg::SPS_SPEED) begin
      cur_pos <= 32'h0000_0000;
    end else if (pos_step) begin
      cur_pos <= pos_dir ? (cur_pos - 32'h0000_0001) : (cur_pos + 32'h0000_0001);
    end
  end

  assign pos_err  = cur_pos - reg_target;
  assign err_abs  = abs32(pos_err);
  assign in_range = ({2'h0, err_abs} <=
                     34'(completion_range) * 34'(`SPS_RANGE_MULT));
  // decel point: decel travel plus creep travel, 100.0% per rev
  assign lhs_near = 48'(err_abs) * 48'(`SPS_PCT_SCALE);
  assign rhs_near = 48'(decel_distance) * 48'(`SPS_PCT_SCALE) +
                    48'(creep_displacement) * 48'(PULSES_REV);
  assign near_target = (lhs_near <= rhs_near);
  assign current_ok  = ({3'h0, release_current_limit} <= output_current);

  // ----
  // sequencer
  // ----
  always_comb begin
    next_state = state;
    case (state)
      sps_pkg::SPS_IDLE: begin
        if (run_cmd) begin
          if (!pos_on) begin
            next_state = sps_pkg::SPS_SPEED;
          end else if (switch_ok && speed_position_switch) begin
            next_state = brake_link ? sps_pkg::SPS_CREEP_UP : sps_pkg::SPS_SPEED;
          end else if (in_range) begin
            next_state = sps_pkg::SPS_HOLD;
          end else begin
            next_state = brake_link ? sps_pkg::SPS_CREEP_UP : sps_pkg::SPS_RUN;
          end
        end
      end
      sps_pkg::SPS_SPEED: begin
        if (!run_cmd) begin
          next_state = brake_link ? sps_pkg::SPS_DECEL : sps_pkg::SPS_IDLE;
        end else if (switch_ok && !speed_position_switch) begin
          if (reg_target == 32'h0000_0000) begin
            next_state = brake_link ? sps_pkg::SPS_DECEL : sps_pkg::SPS_HOLD;
          end else begin
            next_state = sps_pkg::SPS_RUN;
          end
        end
      end
      sps_pkg::SPS_CREEP_UP: begin
        if (!run_cmd) begin
          next_state = sps_pkg::SPS_IDLE;
        end else if (output_freq >= creep_freq) begin
          next_state = sps_pkg::SPS_REL_WAIT;
        end
      end
      sps_pkg::SPS_REL_WAIT: begin
        if (!run_cmd) begin
          next_state = sps_pkg::SPS_IDLE;
        end else if (tmr_done) begin
          if (!current_ok) begin
            next_state = sps_pkg::SPS_TRIP;
          end else begin
            next_state = answer_assigned ? sps_pkg::SPS_ANS_ON : sps_pkg::SPS_ACC_WAIT;
          end
        end
      end
      sps_pkg::SPS_ANS_ON: begin
        if (brake_answer_in) begin
          next_state = sps_pkg::SPS_ACC_WAIT;
        end else if (tmr_done) begin
          next_state = sps_pkg::SPS_TRIP;
        end
      end
      sps_pkg::SPS_ACC_WAIT: begin
        if (tmr_done) begin
          next_state = via_spd ? sps_pkg::SPS_SPEED : sps_pkg::SPS_RUN;
        end
      end
      sps_pkg::SPS_RUN: begin
        if (!run_cmd || near_target) begin
          next_state = sps_pkg::SPS_DECEL;
        end
      end
      sps_pkg::SPS_DECEL: begin
        if (!brake_link) begin
          if (in_range || !run_cmd) begin
            next_state = sps_pkg::SPS_HOLD;
          end
        end else if (output_freq <= creep_freq) begin
          next_state = answer_assigned ? sps_pkg::SPS_ANS_OFF : sps_pkg::SPS_STOP_WAIT;
        end
      end
      sps_pkg::SPS_ANS_OFF: begin
        if (!brake_answer_in) begin
          next_state = sps_pkg::SPS_STOP_WAIT;
        end else if (tmr_done) begin
          next_state = sps_pkg::SPS_TRIP;
        end
      end
      sps_pkg::SPS_STOP_WAIT: begin
        if (tmr_done) begin
          next_state = sps_pkg::SPS_HOLD;
        end
      end
      sps_pkg::SPS_HOLD: begin
        if (!run_cmd) begin
          next_state = sps_pkg::SPS_IDLE;
        end
      end
      sps_pkg::SPS_TRIP: begin
        if (clr_req && !run_cmd) begin
          next_state = sps_pkg::SPS_IDLE;
        end
      end
      default: begin
        next_state = sps_pkg::SPS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= sps_pkg::SPS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      via_spd <= 1'b0;
    end else if (state == sps_pkg::SPS_IDLE) begin
      via_spd <= switch_ok & speed_position_switch;
    end
  end

  // trip clear request from software, dropped when trip leaves
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clr_req <= 1'b0;
    end else if (wr_status) begin
      clr_req <= 1'b1;
    end else if (state != sps_pkg::SPS_TRIP) begin
      clr_req <= 1'b0;
    end
  end

  // ----
  // phase timer, restarted on each state entry
  // ----
  always_comb begin
    case (next_state)
      sps_pkg::SPS_REL_WAIT:  tmr_load = release_wait_time;
      sps_pkg::SPS_ANS_ON:    tmr_load = confirm_timeout;
      sps_pkg::SPS_ANS_OFF:   tmr_load = confirm_timeout;
      sps_pkg::SPS_ACC_WAIT:  tmr_load = accel_wait_time;
      sps_pkg::SPS_STOP_WAIT: tmr_load = stop_wait_time;
      default:                tmr_load = 9'h000;
    endcase
  end

  assign tmr_start = (next_state != state);

  sps_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .clk    (clk),
    .resetn (resetn),
    .start  (tmr_start),
    .load   (tmr_load),
    .done   (tmr_done)
  );

  // ----
  // terminal outputs
  // ----
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      brake_release_out <= 1'b0;
    end else begin
      case (next_state)
        sps_pkg::SPS_ANS_ON, sps_pkg::SPS_ACC_WAIT, sps_pkg::SPS_RUN,
        sps_pkg::SPS_DECEL, sps_pkg::SPS_SPEED:
          brake_release_out <= brake_link;
        default:
          brake_release_out <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      brake_error_out  <= 1'b0;
      brake_error_trip <= 1'b0;
    end else begin
      brake_error_out  <= (next_state == sps_pkg::SPS_TRIP);
      brake_error_trip <= (next_state == sps_pkg::SPS_TRIP);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      positioning_complete_out <= 1'b0;
    end else begin
      positioning_complete_out <= pos_on & in_range &
                                  (state != sps_pkg::SPS_SPEED);
    end
  end

  // ----
  // drive commands
  // ----
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      freq_cmd <= 16'h0000;
    end else begin
      case (state)
        sps_pkg::SPS_SPEED, sps_pkg::SPS_RUN:
          freq_cmd <= set_freq;
        sps_pkg::SPS_CREEP_UP, sps_pkg::SPS_REL_WAIT, sps_pkg::SPS_ANS_ON,
        sps_pkg::SPS_ACC_WAIT, sps_pkg::SPS_DECEL, sps_pkg::SPS_ANS_OFF,
        sps_pkg::SPS_STOP_WAIT:
          freq_cmd <= creep_freq;
        default:
          freq_cmd <= 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dir_reverse <= 1'b0;
    end else if (state == sps_pkg::SPS_SPEED || !pos_on) begin
      dir_reverse <= run_dir;
    end else begin
      dir_reverse <= pos_err[31];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      drive_enable <= 1'b0;
      dc_brake_out <= 1'b0;
    end else begin
      case (state)
        sps_pkg::SPS_IDLE, sps_pkg::SPS_TRIP: begin
          drive_enable <= 1'b0;
          dc_brake_out <= 1'b0;
        end
        sps_pkg::SPS_HOLD: begin
          drive_enable <= dc_at_stop & run_cmd;
          dc_brake_out <= dc_at_stop & run_cmd;
        end
        default: begin
          drive_enable <= 1'b1;
          dc_brake_out <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      speed_mode_out <= 1'b0;
    end else begin
      speed_mode_out <= (next_state == sps_pkg::SPS_SPEED);
    end
  end

  // ----
  // read path
  // ----
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !bus_ack) begin
      case (avs_address)
        `SPS_OFS_CTRL:   avs_readdata <= reg_ctrl;
        `SPS_OFS_TIMEA:  avs_readdata <= reg_timea;
        `SPS_OFS_TIMEB:  avs_readdata <= reg_timeb;
        `SPS_OFS_LIMIT:  avs_readdata <= reg_limit;
        `SPS_OFS_CREEP:  avs_readdata <= reg_creep;
        `SPS_OFS_RANGE:  avs_readdata <= reg_range;
        `SPS_OFS_TARGET: avs_readdata <= reg_target;
        `SPS_OFS_STATUS: avs_readdata <= {24'h00_0000, brake_answer_in, positioning_complete_out,
                                          brake_error_trip, brake_release_out, state};
        `SPS_OFS_POS:    avs_readdata <= cur_pos;
        default:         avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// [tb/sps_brake_model.sv]
`timescale 1ns/100ps
module sps_brake_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // brake coil and answer contact
  input  wire logic       release_in,
  input  wire logic [1:0] lag_mode,
  output      logic       answer_out
);
  logic [2:0] cnt;
  // contact follows coil after 0 or 3 cycles; mode 2 sticks (failed brake)
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt        <= 3'h0;
      answer_out <= 1'b0;
    end else if (release_in == answer_out || lag_mode == 2'h2) begin
      cnt <= 3'h0;
    end else if (cnt >= 3'(lag_mode * 3)) begin
      answer_out <= release_in;
      cnt        <= 3'h0;
    end else begin
      cnt <= cnt + 3'h1;
    end
  end
endmodule

// [tb/sps_seq_asserts.sv]
`timescale 1ns/100ps
module sps_seq_asserts (
  // clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // commands
  input wire logic        run_cmd,
  input wire logic        run_dir,
  input wire logic [15:0] set_freq,
  // outputs under check
  input wire logic        brake_release_out,
  input wire logic        brake_error_out,
  input wire logic        brake_error_trip,
  input wire logic        positioning_complete_out,
  input wire logic [15:0] freq_cmd,
  input wire logic        dir_reverse,
  input wire logic        dc_brake_out,
  input wire logic        drive_enable,
  input wire logic        speed_mode_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_ERR_PAIR: assert property (brake_error_out == brake_error_trip)
    else $error("brake error output differs from trip");
  AST_TRIP_STICKY: assert property (brake_error_trip && run_cmd |=> brake_error_trip)
    else $error("trip left while run command high");
  AST_TRIP_NO_DC: assert property (brake_error_trip && $past(brake_error_trip) |-> !dc_brake_out)
    else $error("dc braking during trip");
  AST_SPEED_DIR: assert property (speed_mode_out && $past(speed_mode_out) |-> dir_reverse == $past(run_dir))
    else $error("speed mode direction not from run command");
  AST_SPEED_FREQ: assert property (speed_mode_out && $past(speed_mode_out) |-> freq_cmd == $past(set_freq))
    else $error("speed mode frequency not set frequency");
  AST_SPEED_NO_POK: assert property (speed_mode_out && $past(speed_mode_out) |-> !positioning_complete_out)
    else $error("complete flagged in speed mode");
  AST_DC_ENABLED: assert property (dc_brake_out |-> drive_enable)
    else $error("dc braking with output cut");
  AST_DC_RUN_DROP: assert property ($fell(run_cmd) |-> ##2 !dc_brake_out)
    else $error("dc braking kept after run drop");
  cover property ($rose(brake_release_out));
  cover property ($rose(brake_error_trip));
  cover property ($rose(dc_brake_out));
endmodule
bind sps_seq sps_seq_asserts i_sps_seq_asserts (.clk(clk), .resetn(resetn), .run_cmd(run_cmd), .run_dir(run_dir),
  .set_freq(set_freq), .brake_release_out(brake_release_out), .brake_error_out(brake_error_out),
  .brake_error_trip(brake_error_trip), .positioning_complete_out(positioning_complete_out), .freq_cmd(freq_cmd),
  .dir_reverse(dir_reverse), .dc_brake_out(dc_brake_out), .drive_enable(drive_enable),
  .speed_mode_out(speed_mode_out));

// [tb/tb_top.sv]
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; $display("Error at %0t: mismatch", $time); end end
`define WAITC(c) begin for (wt = 0; wt < 2000 && !(c); wt++) @(posedge clk); if (wt == 2000) begin failures++; summarize(); end end
module tb_top;
  logic        clk = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [5:0]  avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic        run_cmd = 1'b0, run_dir = 1'b0, pos_step = 1'b0, pos_dir = 1'b0, sw = 1'b0, linked = 1'b0;
  logic [15:0] set_freq = 16'h0BB8, output_freq = 16'h0000, freq_cmd;
  logic [7:0]  output_current = 8'h0A;
  logic [1:0]  lag_mode = 2'h1;
  logic        brake_answer_in, brake_release_out, brake_error_out, brake_error_trip, positioning_complete_out;
  logic        dir_reverse, dc_brake_out, drive_enable, speed_mode_out;
  int          failures = 0, checks = 0, wt, pos_m = 0, tgt, n0, brk_cnt = 0;
  logic [31:0] img [int];
  always #2 clk = ~clk;
  sps_seq #(.TICK_CYCLES(4)) i_sps_seq (.clk(clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'hF), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .run_cmd(run_cmd), .run_dir(run_dir),
    .set_freq(set_freq), .output_freq(output_freq), .output_current(output_current), .decel_distance(32'h0),
    .pos_step(pos_step), .pos_dir(pos_dir), .speed_position_switch(sw), .brake_answer_in(brake_answer_in),
    .brake_release_out(brake_release_out), .brake_error_out(brake_error_out), .brake_error_trip(brake_error_trip),
    .positioning_complete_out(positioning_complete_out), .freq_cmd(freq_cmd), .dir_reverse(dir_reverse),
    .dc_brake_out(dc_brake_out), .drive_enable(drive_enable), .speed_mode_out(speed_mode_out));
  sps_brake_model i_sps_brake_model (.clk(clk), .resetn(resetn), .release_in(brake_release_out),
    .lag_mode(lag_mode), .answer_out(brake_answer_in));
  // load: frequency follows command, shaft turns only when the brake is open or not linked
  always @(posedge clk) begin
    output_freq <= freq_cmd;
    pos_step    <= !pos_step && (freq_cmd != 16'h0000) && (brake_release_out || !linked);
    pos_dir     <= ~dir_reverse;
    if (brake_release_out) brk_cnt <= brk_cnt + 1;
    if (pos_step) pos_m <= pos_dir ? pos_m - 1 : pos_m + 1;
  end
  task automatic summarize;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    for (n = 0; n < 20; n++) begin
      @(negedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 20) begin failures++; summarize(); end
    @(posedge clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (wr && a < 6'h24) img[a] = d;
    @(posedge clk);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask
  task automatic clear_trip;
    run_cmd <= 1'b0;
    bus(1'b1, 6'h1C, 32'h0000_0020);
    `WAITC(brake_error_trip === 1'b0)
  endtask
  initial begin
    void'($urandom(32'h594302d9));
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    // ----
    // register defaults and readback
    // ----
    rd(6'h00, 32'h0);
    rd(6'h1C, 32'h0);
    tgt = 150 + ($urandom % 150);
    bus(1'b1, 6'h04, 32'h0001_0001);
    bus(1'b1, 6'h08, 32'h0002_0001);
    bus(1'b1, 6'h0C, 32'h0064_0005);
    bus(1'b1, 6'h10, 32'h0000_000A);
    bus(1'b1, 6'h14, 32'h0000_0014);
    bus(1'b1, 6'h18, 32'(tgt));
    bus(1'b1, 6'h3C, 32'hFFFF_FFFF);
    foreach (img[a]) rd(6'(a), img[a]);
    rd(6'h3C, 32'h0);
    $display("test registers done");
    // ----
    // brake-linked run, slow answer contact
    // ----
    linked   <= 1'b1;
    set_freq <= 16'(1000 + $urandom % 4000);
    bus(1'b1, 6'h00, 32'h0101_0002);
    run_cmd <= 1'b1;
    `WAITC(brake_answer_in === 1'b1)
    `CHK(freq_cmd, 16'h0064)
    `WAITC(dc_brake_out === 1'b1)
    `CHK((tgt - pos_m) inside {[0:40]}, 1'b1)
    `CHK(positioning_complete_out, 1'b1)
    `CHK(brake_release_out, 1'b0)
    `CHK(drive_enable, 1'b1)
    rd(6'h20, 32'(pos_m));
    run_cmd <= 1'b0;
    `WAITC(drive_enable === 1'b0)
    $display("test brake run done");
    // ----
    // low current at release, then dead answer
    // ----
    bus(1'b1, 6'h18, 32'(pos_m + 1000));
    output_current <= 8'h02;
    n0 = brk_cnt;
    run_cmd <= 1'b1;
    `WAITC(brake_error_trip === 1'b1)
    `CHK(brk_cnt === n0, 1'b1)
    `CHK(brake_error_out, 1'b1)
    clear_trip();
    output_current <= 8'h0A;
    lag_mode       <= 2'h2;
    run_cmd        <= 1'b1;
    `WAITC(brake_release_out === 1'b1)
    for (wt = 0; wt < 20 && brake_error_trip !== 1'b1; wt++) @(posedge clk);
    `CHK(wt inside {[6:12]}, 1'b1)
    `CHK(brake_error_out, 1'b1)
    clear_trip();
    $display("test brake errors done");
    // ----
    // speed/position switching
    // ----
    linked   <= 1'b0;
    lag_mode <= 2'h0;
    run_dir  <= 1'($urandom);
    bus(1'b1, 6'h00, 32'h0000_0002);
    n0 = brk_cnt;
    sw      <= 1'b1;
    run_cmd <= 1'b1;
    `WAITC(speed_mode_out === 1'b1)
    repeat (20) @(posedge clk);
    `CHK(dir_reverse, run_dir)
    `CHK(freq_cmd, set_freq)
    rd(6'h20, 32'h0);
    bus(1'b1, 6'h18, 32'h0);
    sw <= 1'b0;
    `WAITC(speed_mode_out === 1'b0)
    repeat (3) @(posedge clk);
    bus(1'b0, 6'h1C, 32'h0);
    `CHK(q[3:0], 4'hD)
    `CHK(brk_cnt === n0, 1'b1)
    run_cmd <= 1'b0;
    repeat (4) @(posedge clk);
    bus(1'b1, 6'h00, 32'h0000_0102);
    sw      <= 1'b1;
    run_cmd <= 1'b1;
    repeat (20) @(posedge clk);
    `CHK(speed_mode_out, 1'b0)
    $display("test switching done");
    summarize();
  end
endmodule
